/* cbft_consts.vh */
/*
 * Constants for the bit, flag and transfer execution unit: status bit
 * positions, operation codes, pointer selects and cycle counts.
 * Assumes inclusion by bare name from the unit's design files.
 */
`ifndef CBFT_CONSTS_VH
`define CBFT_CONSTS_VH

`define CBFT_FLAG_C 3'd0
`define CBFT_FLAG_Z 3'd1
`define CBFT_FLAG_N 3'd2
`define CBFT_FLAG_V 3'd3
`define CBFT_FLAG_S 3'd4
`define CBFT_FLAG_H 3'd5
`define CBFT_FLAG_T 3'd6
`define CBFT_FLAG_I 3'd7
`define CBFT_STATUS_RESET 8'h00

`define CBFT_OP_NOP 5'd0
`define CBFT_OP_BIT_TO_T 5'd1
`define CBFT_OP_T_TO_BIT 5'd2
`define CBFT_OP_FLAG_SET 5'd3
`define CBFT_OP_FLAG_CLEAR 5'd4
`define CBFT_OP_SHIFT_RIGHT 5'd5
`define CBFT_OP_SWAP 5'd6
`define CBFT_OP_FETCH 5'd7
`define CBFT_OP_FETCH_INC 5'd8
`define CBFT_OP_FETCH_DEC 5'd9
`define CBFT_OP_FETCH_OFS 5'd10
`define CBFT_OP_FETCH_DIR 5'd11
`define CBFT_OP_WRITE 5'd12
`define CBFT_OP_WRITE_INC 5'd13
`define CBFT_OP_WRITE_DEC 5'd14
`define CBFT_OP_WRITE_OFS 5'd15
`define CBFT_OP_WRITE_DIR 5'd16
`define CBFT_OP_PROG_FETCH 5'd17
`define CBFT_OP_PROG_FETCH_INC 5'd18
`define CBFT_OP_PUSH 5'd19
`define CBFT_OP_POP 5'd20
`define CBFT_OP_SLEEP 5'd21
`define CBFT_OP_WDOG 5'd22
`define CBFT_OP_BREAK 5'd23

`define CBFT_PTR_X 2'd0
`define CBFT_PTR_Y 2'd1
`define CBFT_PTR_Z 2'd2

`define CBFT_REG_X_LO 5'd26
`define CBFT_REG_Y_LO 5'd28
`define CBFT_REG_Z_LO 5'd30

`define CBFT_CYC_DATA 2'd2
`define CBFT_CYC_PROG 2'd3
`define CBFT_SP_RESET 16'h0000

`endif

/* cbft_regfile.v */
/*
 * General register file: 32 bytes, one write port, two registered read ports.
 * Assumes the owner presents addresses a cycle before it needs the data.
 */
`timescale 1ns/100ps
`default_nettype none

module cbft_regfile #(
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock,          // Core clock.
    input wire we,             // Write enable.
    input wire [AW-1:0] waddr, // Write address.
    input wire [7:0] wdata,    // Write data.
    input wire [AW-1:0] raddr_a, // Read address A.
    input wire [AW-1:0] raddr_b, // Read address B.
    output reg [7:0] rdata_a,  // Registered read data A.
    output reg [7:0] rdata_b   // Registered read data B.
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule // cbft_regfile

`default_nettype wire

/* cbft_exec.v */
/*
 * Execution unit for bit and flag operations, data and program memory
 * transfers, stack push and pop, and core control operations.
 * Assumes a decoded operation is offered with op_valid while op_ready is
 * high, and that data memory reads return one cycle after the request.
 */
// Contract
// RQ1: Bit-to-transfer-flag copies selected source bit into T, one clock, only T.
// RQ2: Transfer-flag-to-bit writes T into selected destination bit, one clock, no flags.
// RQ3: Sign flag set and clear instructions force S only, one clock.
// RQ4: Overflow flag set and clear instructions force V only, one clock.
// RQ5: Half carry set and clear instructions force H only, one clock.
// RQ6: Post-increment load reads at pointer, then pointer plus one, two clocks; the code takes three.
// RQ7: Pre-decrement load decrements pointer first, reads new address, two clocks; the code takes three.
// RQ8: Displaced load reads Y or Z plus displacement, pointer kept, two clocks; the code takes three.
// RQ9: Direct load reads the encoded address into destination, two clocks; the code takes three.
// RQ10: Post-increment store writes at pointer, then increments it, two clocks.
// RQ11: Pre-decrement store decrements pointer, writes at new address, two clocks.
// RQ12: Displaced store writes at Y or Z plus displacement, pointer kept.
// RQ13: Direct store writes source to encoded address, two clocks, no flags.
// RQ14: Program fetch loads Z-addressed byte into R0 or register, three clocks.
// RQ15: Push places source on stack in two clocks, flags untouched.
// RQ16: Pop takes top stack byte into destination in two clocks; the code takes three.
// RQ17: Sleep issues in one clock, no flags, then signals sleep request.
// RQ18: Watchdog restart takes one clock, no flags, pulses restart.
// RQ19: Break only signals the debugger; no flags change.
// RQ20: Arithmetic right shift keeps bit seven, updates Z, C, N, V.
// RQ21: Nibble exchange swaps register halves in one clock, no flags.
// RQ22: Global interrupt on and off set or clear I in one clock.
`timescale 1ns/100ps
`default_nettype none
`include "cbft_consts.vh"

module cbft_exec #(
    parameter DADDR_W = 16,
    parameter PADDR_W = 16
) (
    input wire clock,               // Core clock, 40 MHz.
    input wire rstn,                // Asynchronous reset, active low.
    input wire op_valid,            // Decoded operation offered.
    output wire op_ready,           // Unit idle and able to take an operation.
    input wire [4:0] op_code,       // Operation code.
    input wire [4:0] op_rd,         // Destination or source register index.
    input wire [2:0] op_bit,        // Bit or status flag select.
    input wire [1:0] op_ptr,        // Pointer pair select.
    input wire [5:0] op_disp,       // Displacement.
    input wire [15:0] op_addr,      // Direct address.
    input wire op_to_r0,            // Program fetch to register zero.
    output reg [7:0] status_register, // Status flags.
    output reg [DADDR_W-1:0] dmem_addr, // Data memory address.
    output reg [7:0] dmem_wdata,    // Data memory write data.
    output reg dmem_we,             // Data memory write strobe.
    output reg dmem_re,             // Data memory read strobe.
    input wire [7:0] dmem_rdata,    // Data memory read data, one cycle later.
    output reg [PADDR_W-1:0] pmem_addr, // Program memory byte address.
    output reg pmem_re,             // Program memory read strobe.
    input wire [7:0] pmem_rdata,    // Program memory data, one cycle later.
    output reg sleep_req,           // Sleep request pulse.
    output reg wdog_restart,        // Watchdog restart pulse.
    output reg break_req,           // Debug break pulse.
    output reg [15:0] stack_ptr     // Stack pointer.
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_READ = 4'b0010;
    localparam ST_EXEC = 4'b0100;
    localparam ST_WAIT = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [4:0] cur_op;
    reg [4:0] cur_rd;
    reg [2:0] cur_bit;
    reg [1:0] cur_ptr;
    reg [5:0] cur_disp;
    reg [15:0] cur_addr;
    reg cur_r0;
    reg [15:0] ptr_hold;

    reg rf_we;
    reg [4:0] rf_waddr;
    reg [7:0] rf_wdata;
    reg [4:0] rf_ra;
    reg [4:0] rf_rb;
    wire [7:0] rf_da;
    wire [7:0] rf_db;

    cbft_regfile #(.DEPTH(32), .AW(5)) u_regs (
        .clock(clock),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr_a(rf_ra),
        .raddr_b(rf_rb),
        .rdata_a(rf_da),
        .rdata_b(rf_db)
    );

    // The pointer pair is read through both ports as low and high byte.
    reg [4:0] ptr_lo_idx;
    always @* begin
        case (op_valid && state == ST_IDLE ? op_ptr : cur_ptr)
            `CBFT_PTR_X: ptr_lo_idx = `CBFT_REG_X_LO;
            `CBFT_PTR_Y: ptr_lo_idx = `CBFT_REG_Y_LO;
            default: ptr_lo_idx = `CBFT_REG_Z_LO;
        endcase
    end

    assign op_ready = (state == ST_IDLE);

    wire take = op_valid && op_ready;
    wire [15:0] ptr_val = {rf_db, rf_da};
    wire [15:0] ptr_inc = ptr_val + 16'h0001;
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire [15:0] ptr_ofs = ptr_val + {10'h000, cur_disp};
    wire is_mem_op = (cur_op >= `CBFT_OP_FETCH) && (cur_op <= `CBFT_OP_POP);
    wire cur_store = (cur_op >= `CBFT_OP_WRITE) && (cur_op <= `CBFT_OP_WRITE_DIR);
    wire cur_fetch = (cur_op >= `CBFT_OP_FETCH) && (cur_op <= `CBFT_OP_FETCH_DIR);
    wire cur_prog = (cur_op == `CBFT_OP_PROG_FETCH) || (cur_op == `CBFT_OP_PROG_FETCH_INC);

    // Register-file read addresses: data operand on A/B in the issue cycle, or pointer low/high
    // for fetch, store and program-fetch operations; store or push data on A in the ST_READ cycle.
    always @* begin
        rf_ra = take ? op_rd : ptr_lo_idx;
        rf_rb = take ? op_rd : (ptr_lo_idx + 5'd1);
        if (state == ST_READ) begin
            // Stores fetch their data byte now, for the strobe in the access cycle.
            rf_ra = (cur_store || cur_op == `CBFT_OP_PUSH) ? cur_rd : ptr_lo_idx;
            rf_rb = ptr_lo_idx + 5'd1;
        end
        if (take && op_code >= `CBFT_OP_FETCH && op_code <= `CBFT_OP_PROG_FETCH_INC) begin
            rf_ra = ptr_lo_idx;
            rf_rb = ptr_lo_idx + 5'd1;
        end
    end

    // Index of the pointer high byte, kept for its late write-back.
    reg [4:0] hold_idx;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                next_state = (is_mem_op && cur_op != `CBFT_OP_PUSH &&
                              cur_op != `CBFT_OP_POP) ? ST_EXEC : ST_IDLE;
                if (cur_op == `CBFT_OP_PUSH || cur_op == `CBFT_OP_POP) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // Read data arrive one cycle after the strobe, so loads wait too.
                next_state = (cur_prog || cur_fetch || cur_op == `CBFT_OP_POP) ?
                             ST_WAIT : ST_IDLE;
            end
            ST_WAIT: begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Register-file writes: result of single-cycle work, loaded data,
    // and the updated pointer pair (two bytes over two cycles).
    reg ptr_hi_pend;
    always @* begin
        rf_we = 1'b0;
        rf_waddr = cur_rd;
        rf_wdata = 8'h00;
        if (state == ST_READ) begin
            case (cur_op)
                `CBFT_OP_T_TO_BIT: begin
                    rf_we = 1'b1;
                    rf_wdata = rf_da;
                    rf_wdata[cur_bit] = status_register[`CBFT_FLAG_T]; // [RQ2]
                end
                `CBFT_OP_SHIFT_RIGHT: begin
                    rf_we = 1'b1;
                    rf_wdata = {rf_da[7], rf_da[7:1]}; // [RQ20]
                end
                `CBFT_OP_SWAP: begin
                    rf_we = 1'b1;
                    rf_wdata = {rf_da[3:0], rf_da[7:4]}; // [RQ21]
                end
                `CBFT_OP_FETCH_INC, `CBFT_OP_WRITE_INC, `CBFT_OP_PROG_FETCH_INC: begin
                    rf_we = 1'b1;
                    rf_waddr = ptr_lo_idx;
                    rf_wdata = ptr_inc[7:0]; // [RQ6] [RQ10] [RQ14]
                end
                `CBFT_OP_FETCH_DEC, `CBFT_OP_WRITE_DEC: begin
                    rf_we = 1'b1;
                    rf_waddr = ptr_lo_idx;
                    rf_wdata = ptr_dec[7:0]; // [RQ7] [RQ11]
                end
                default: rf_we = 1'b0;
            endcase
        end else if (state == ST_WAIT) begin
            rf_we = 1'b1;
            rf_waddr = (cur_prog && cur_r0) ? 5'd0 : cur_rd;
            rf_wdata = cur_prog ? pmem_rdata : dmem_rdata; // [RQ8] [RQ9] [RQ14] [RQ16]
        end else if (state == ST_IDLE && ptr_hi_pend) begin
            rf_we = 1'b1;
            rf_waddr = hold_idx;
            rf_wdata = ptr_hold[15:8];
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cur_op <= `CBFT_OP_NOP;
            cur_rd <= 5'd0;
            cur_bit <= 3'd0;
            cur_ptr <= 2'd0;
            cur_disp <= 6'd0;
            cur_addr <= 16'h0000;
            cur_r0 <= 1'b0;
            hold_idx <= 5'd0;
        end else begin
            state <= next_state;
            if (take) begin
                cur_op <= op_code;
                cur_rd <= op_rd;
                cur_bit <= op_bit;
                cur_ptr <= op_ptr;
                cur_disp <= op_disp;
                cur_addr <= op_addr;
                cur_r0 <= op_to_r0;
            end
            if (state == ST_READ) begin
                hold_idx <= ptr_lo_idx + 5'd1;
            end
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_register <= `CBFT_STATUS_RESET;
            dmem_addr <= {DADDR_W{1'b0}};
            dmem_wdata <= 8'h00;
            dmem_we <= 1'b0;
            dmem_re <= 1'b0;
            pmem_addr <= {PADDR_W{1'b0}};
            pmem_re <= 1'b0;
            sleep_req <= 1'b0;
            wdog_restart <= 1'b0;
            break_req <= 1'b0;
            stack_ptr <= `CBFT_SP_RESET;
            ptr_hold <= 16'h0000;
            ptr_hi_pend <= 1'b0;
        end else begin
            dmem_we <= 1'b0;
            dmem_re <= 1'b0;
            pmem_re <= 1'b0;
            sleep_req <= 1'b0;
            wdog_restart <= 1'b0;
            break_req <= 1'b0;
            if (state == ST_IDLE) begin
                ptr_hi_pend <= 1'b0;
            end
            if (take) begin
                case (op_code)
                    `CBFT_OP_FLAG_SET: status_register[op_bit] <= 1'b1; // [RQ3] [RQ4] [RQ5] [RQ22]
                    `CBFT_OP_FLAG_CLEAR: status_register[op_bit] <= 1'b0; // [RQ3] [RQ4] [RQ5] [RQ22]
                    `CBFT_OP_SLEEP: sleep_req <= 1'b1; // [RQ17]
                    `CBFT_OP_WDOG: wdog_restart <= 1'b1; // [RQ18]
                    `CBFT_OP_BREAK: break_req <= 1'b1; // [RQ19]
                    default: status_register <= status_register;
                endcase
            end
            if (state == ST_READ) begin
                case (cur_op)
                    `CBFT_OP_BIT_TO_T: status_register[`CBFT_FLAG_T] <= rf_da[cur_bit]; // [RQ1]
                    `CBFT_OP_SHIFT_RIGHT: begin
                        status_register[`CBFT_FLAG_C] <= rf_da[0]; // [RQ20]
                        status_register[`CBFT_FLAG_Z] <= (rf_da[7:1] == 7'h00) && !rf_da[7];
                        status_register[`CBFT_FLAG_N] <= rf_da[7];
                        status_register[`CBFT_FLAG_V] <= rf_da[7] ^ rf_da[0];
                    end
                    `CBFT_OP_FETCH, `CBFT_OP_FETCH_INC, `CBFT_OP_WRITE,
                    `CBFT_OP_WRITE_INC: begin
                        dmem_addr <= ptr_val[DADDR_W-1:0];
                        ptr_hold <= ptr_inc;
                        ptr_hi_pend <= (cur_op == `CBFT_OP_FETCH_INC) ||
                                       (cur_op == `CBFT_OP_WRITE_INC); // [RQ6] [RQ10]
                    end
                    `CBFT_OP_FETCH_DEC, `CBFT_OP_WRITE_DEC: begin
                        dmem_addr <= ptr_dec[DADDR_W-1:0]; // [RQ7] [RQ11]
                        ptr_hold <= ptr_dec;
                        ptr_hi_pend <= 1'b1;
                    end
                    `CBFT_OP_FETCH_OFS, `CBFT_OP_WRITE_OFS: begin
                        dmem_addr <= ptr_ofs[DADDR_W-1:0]; // [RQ8] [RQ12]
                    end
                    `CBFT_OP_FETCH_DIR, `CBFT_OP_WRITE_DIR: begin
                        dmem_addr <= cur_addr[DADDR_W-1:0]; // [RQ9] [RQ13]
                    end
                    `CBFT_OP_PROG_FETCH, `CBFT_OP_PROG_FETCH_INC: begin
                        pmem_addr <= ptr_val[PADDR_W-1:0]; // [RQ14]
                        pmem_re <= 1'b1;
                        ptr_hold <= ptr_inc;
                        ptr_hi_pend <= (cur_op == `CBFT_OP_PROG_FETCH_INC);
                    end
                    `CBFT_OP_PUSH: begin
                        dmem_addr <= stack_ptr[DADDR_W-1:0]; // [RQ15]
                        stack_ptr <= stack_ptr - 16'h0001;
                    end
                    `CBFT_OP_POP: begin
                        dmem_addr <= stack_ptr[DADDR_W-1:0] + 1'b1; // [RQ16]
                        stack_ptr <= stack_ptr + 16'h0001;
                    end
                    default: ptr_hi_pend <= 1'b0;
                endcase
                dmem_re <= cur_fetch || (cur_op == `CBFT_OP_POP);
            end
            if (state == ST_EXEC && (cur_store || cur_op == `CBFT_OP_PUSH)) begin
                dmem_we <= 1'b1; // [RQ10] [RQ11] [RQ12] [RQ13] [RQ15]
                dmem_wdata <= rf_da;
            end
        end
    end
endmodule // cbft_exec

`default_nettype wire

/* cbft_mem_model.sv */
/* Data and program memory standing behind the execution unit.
   Assumes byte addresses whose low eight bits select the entry. */
`timescale 1ns/100ps
`default_nettype none
module cbft_mem_model #(parameter DADDR_W = 16, parameter PADDR_W = 16) (
    input wire logic clock, // Core clock.
    input wire logic [DADDR_W-1:0] dmem_addr, // Data address.
    input wire logic [7:0] dmem_wdata, // Write data.
    input wire logic dmem_we, // Write strobe.
    input wire logic dmem_re, // Read strobe.
    output logic [7:0] dmem_rdata, // Read data.
    input wire logic [PADDR_W-1:0] pmem_addr, // Program address.
    input wire logic pmem_re, // Program read strobe.
    output logic [7:0] pmem_rdata // Program data.
);
    logic [7:0] dmem [0:255];
    logic [7:0] pmem [0:255];
    logic pm_hold = 0;
    initial dmem_rdata = 8'h00;
    initial pmem_rdata = 8'h00;
    // Stale data is inverted so a late sample never matches by luck, except program data, which holds one cycle longer.
    always @(posedge clock) begin
        if (dmem_we) dmem[dmem_addr[7:0]] <= dmem_wdata;
        if (dmem_re) dmem_rdata <= dmem[dmem_addr[7:0]];
        else dmem_rdata <= ~dmem_rdata;
        pm_hold <= pmem_re;
        if (pmem_re) pmem_rdata <= pmem[pmem_addr[7:0]];
        else if (!pm_hold) pmem_rdata <= ~pmem_rdata;
    end
endmodule // cbft_mem_model
`default_nettype wire

/* cbft_exec_assertions.sv */
/* Port checker for the execution unit: flag effects, strobes and pulses.
   Assumes binding into cbft_exec and the constants header on the path. */
`timescale 1ns/100ps
`default_nettype none
`include "cbft_consts.vh"
module cbft_exec_assertions #(parameter DADDR_W = 16, parameter PADDR_W = 16) (
    input wire logic clock, // Core clock.
    input wire logic rstn, // Reset, active low.
    input wire logic op_valid, // Operation offered.
    input wire logic op_ready, // Unit idle.
    input wire logic [4:0] op_code, // Operation code.
    input wire logic [2:0] op_bit, // Flag select.
    input wire logic [15:0] op_addr, // Direct address.
    input wire logic [7:0] status_register, // Status flags.
    input wire logic [DADDR_W-1:0] dmem_addr, // Data address.
    input wire logic dmem_we, // Write strobe.
    input wire logic dmem_re, // Read strobe.
    input wire logic pmem_re, // Program read strobe.
    input wire logic sleep_req, // Sleep pulse.
    input wire logic wdog_restart, // Watchdog pulse.
    input wire logic break_req // Break pulse.
);
    wire take;
    logic [15:0] cap_addr;
    assign take = op_valid && op_ready;
    always @(posedge clock) if (take) cap_addr <= op_addr;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_set_one_flag: assert property (take && op_code == `CBFT_OP_FLAG_SET |=>
        status_register == ($past(status_register) | (8'h01 << $past(op_bit))))
        else $error("flag set changed the wrong bits");
    a_clear_one_flag: assert property (take && op_code == `CBFT_OP_FLAG_CLEAR |=>
        status_register == ($past(status_register) & ~(8'h01 << $past(op_bit))))
        else $error("flag clear changed the wrong bits");
    a_only_t_moves: assert property (take && op_code == `CBFT_OP_BIT_TO_T |-> ##2
        (status_register & 8'hBF) == ($past(status_register, 2) & 8'hBF))
        else $error("bit to flag touched another flag");
    a_data_flags_kept: assert property (take && op_code inside {[7:20]} |=>
        $stable(status_register)[*4]) else $error("transfer changed a flag");
    a_direct_store: assert property (take && op_code == `CBFT_OP_WRITE_DIR |->
        ##[1:3] dmem_we && dmem_addr == cap_addr[DADDR_W-1:0]) else $error("store address wrong");
    a_direct_load: assert property (take && op_code == `CBFT_OP_FETCH_DIR |->
        ##[1:3] dmem_re && dmem_addr == cap_addr[DADDR_W-1:0]) else $error("load address wrong");
    a_strobe_single: assert property (dmem_we || dmem_re |=> !dmem_we && !dmem_re)
        else $error("data strobe longer than one cycle");
    a_prog_read: assert property (take && op_code inside {17, 18} |-> ##[1:3] pmem_re)
        else $error("program read strobe missing");
    a_sleep_pulse: assert property (take && op_code == `CBFT_OP_SLEEP |=> sleep_req ##1 !sleep_req)
        else $error("sleep pulse wrong");
    a_wdog_pulse: assert property (take && op_code == `CBFT_OP_WDOG |=> wdog_restart ##1 !wdog_restart)
        else $error("watchdog pulse wrong");
    a_break_pulse: assert property ($rose(break_req) |-> $past(take && op_code == `CBFT_OP_BREAK))
        else $error("break pulse without break");
    c_store: cover property (dmem_we);
    c_prog: cover property (pmem_re);
    c_sleep: cover property (sleep_req);
endmodule // cbft_exec_assertions
bind cbft_exec cbft_exec_assertions #(.DADDR_W(DADDR_W), .PADDR_W(PADDR_W)) u_chk (
    .clock(clock), .rstn(rstn), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_bit(op_bit), .op_addr(op_addr), .status_register(status_register),
    .dmem_addr(dmem_addr), .dmem_we(dmem_we), .dmem_re(dmem_re), .pmem_re(pmem_re),
    .sleep_req(sleep_req), .wdog_restart(wdog_restart), .break_req(break_req));
`default_nettype wire

/* tb_cbft_exec.sv */
/* Self-checking bench for the execution unit with its memory model.
   Assumes registers start unknown, so t_direct loads register 1 and the pointer high bytes that later tests use. */
`timescale 1ns/100ps
`default_nettype none
`include "cbft_consts.vh"
module tb_cbft_exec;
    logic clock = 0, rstn = 0, op_valid = 0, op_to_r0 = 0;
    logic [4:0] op_code = 0, op_rd = 0;
    logic [2:0] op_bit = 0;
    logic [1:0] op_ptr = 0;
    logic [5:0] op_disp = 0;
    logic [15:0] op_addr = 0, dmem_addr, pmem_addr, stack_ptr;
    logic [7:0] status_register, dmem_wdata, dmem_rdata, pmem_rdata;
    logic op_ready, dmem_we, dmem_re, pmem_re, sleep_req, wdog_restart, break_req;
    int errors = 0, comparisons = 0, n_sleep = 0, n_wdog = 0, n_brk = 0;
    cbft_exec dut (.clock(clock), .rstn(rstn), .op_valid(op_valid), .op_ready(op_ready),
        .op_code(op_code), .op_rd(op_rd), .op_bit(op_bit), .op_ptr(op_ptr), .op_disp(op_disp),
        .op_addr(op_addr), .op_to_r0(op_to_r0), .status_register(status_register),
        .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
        .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
        .pmem_rdata(pmem_rdata), .sleep_req(sleep_req), .wdog_restart(wdog_restart),
        .break_req(break_req), .stack_ptr(stack_ptr));
    cbft_mem_model mem (.clock(clock), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
        .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr),
        .pmem_re(pmem_re), .pmem_rdata(pmem_rdata));
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) begin
        n_sleep += (sleep_req === 1'b1);
        n_wdog += (wdog_restart === 1'b1);
        n_brk += (break_req === 1'b1);
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task ready_wait;
        int n;
        n = 0;
        while (op_ready !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > 50) begin
                errors++;
                wrap_up;
            end
        end
    endtask
    // Each operation is held until taken, then allowed to finish before the next one.
    task run(input logic [4:0] c, input logic [4:0] r, input logic [2:0] b,
            input logic [1:0] p, input logic [5:0] d, input logic [15:0] a);
        @(posedge clock);
        op_valid <= 1; op_code <= c; op_rd <= r; op_bit <= b; op_ptr <= p; op_disp <= d;
        op_addr <= a;
        @(negedge clock);
        ready_wait;
        @(posedge clock);
        op_valid <= 0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        ready_wait;
    endtask
    task ld(input logic [4:0] r, input logic [15:0] a); run(`CBFT_OP_FETCH_DIR, r, 0, 0, 0, a); endtask
    task st(input logic [4:0] r, input logic [15:0] a); run(`CBFT_OP_WRITE_DIR, r, 0, 0, 0, a); endtask
    task t_direct;
        ld(1, 10); ld(27, 0); ld(29, 0); ld(31, 0); st(1, 20);
        chk(mem.dmem[20], 16'h00A5);
        chk(status_register, 16'h0000);
        $display("t_direct done");
    endtask
    task t_flags;
        logic [2:0] fl [4];
        fl = '{3'd4, 3'd3, 3'd5, 3'd7};
        foreach (fl[i]) begin
            run(`CBFT_OP_FLAG_SET, 0, fl[i], 0, 0, 0);
            chk(status_register, 16'h0001 << fl[i]);
            run(`CBFT_OP_FLAG_CLEAR, 0, fl[i], 0, 0, 0);
            chk(status_register, 16'h0000);
        end
        $display("t_flags done");
    endtask
    task t_tbit;
        run(`CBFT_OP_BIT_TO_T, 1, 5, 0, 0, 0);
        chk(status_register, 16'h0040);
        ld(2, 0); run(`CBFT_OP_T_TO_BIT, 2, 3, 0, 0, 0); st(2, 21);
        chk(mem.dmem[21], 16'h0008);
        chk(status_register, 16'h0040);
        run(`CBFT_OP_FLAG_CLEAR, 0, 6, 0, 0, 0);
        $display("t_tbit done");
    endtask
    task t_ptr;
        ld(26, 1);
        run(`CBFT_OP_FETCH_INC, 3, 0, `CBFT_PTR_X, 0, 0);
        run(`CBFT_OP_WRITE_DEC, 1, 0, `CBFT_PTR_X, 0, 0);
        run(`CBFT_OP_FETCH_DEC, 4, 0, `CBFT_PTR_X, 0, 0);
        run(`CBFT_OP_WRITE_INC, 3, 0, `CBFT_PTR_X, 0, 0);
        st(26, 22); st(4, 23);
        chk(mem.dmem[8'h30], 16'h00A5);
        chk(mem.dmem[8'h2F], 16'h0011);
        chk(mem.dmem[22], 16'h0030);
        chk(mem.dmem[23], 16'h0022);
        $display("t_ptr done");
    endtask
    task t_ofs;
        ld(28, 2);
        run(`CBFT_OP_WRITE_OFS, 1, 0, `CBFT_PTR_Y, 5, 0);
        run(`CBFT_OP_FETCH_OFS, 5, 0, `CBFT_PTR_Y, 6, 0);
        st(5, 24); st(28, 25);
        chk(mem.dmem[8'h45], 16'h00A5);
        chk(mem.dmem[24], 16'h006C);
        chk(mem.dmem[25], 16'h0040);
        $display("t_ofs done");
    endtask
    task t_prog;
        ld(30, 3);
        run(`CBFT_OP_PROG_FETCH_INC, 7, 0, `CBFT_PTR_Z, 0, 0);
        @(posedge clock);
        op_to_r0 <= 1;
        run(`CBFT_OP_PROG_FETCH, 9, 0, `CBFT_PTR_Z, 0, 0);
        @(posedge clock);
        op_to_r0 <= 0;
        st(7, 26); st(0, 27); st(30, 28);
        chk(mem.dmem[26], 16'h005C);
        chk(mem.dmem[27], 16'h003D);
        chk(mem.dmem[28], 16'h0013);
        $display("t_prog done");
    endtask
    task t_shift;
        ld(8, 10); run(`CBFT_OP_SWAP, 8, 0, 0, 0, 0); st(8, 29);
        chk(mem.dmem[29], 16'h005A);
        chk(status_register, 16'h0000);
        ld(9, 10); run(`CBFT_OP_SHIFT_RIGHT, 9, 0, 0, 0, 0); st(9, 31);
        chk(mem.dmem[31], 16'h00D2);
        chk(status_register[3:0], 16'h0005);
        $display("t_shift done");
    endtask
    task t_ctrl;
        run(`CBFT_OP_SLEEP, 0, 0, 0, 0, 0);
        run(`CBFT_OP_WDOG, 0, 0, 0, 0, 0);
        run(`CBFT_OP_BREAK, 0, 0, 0, 0, 0);
        chk(n_sleep, 16'h0001);
        chk(n_wdog, 16'h0001);
        chk(n_brk, 16'h0001);
        chk(status_register[3:0], 16'h0005);
        $display("t_ctrl done");
    endtask
    task t_stack;
        run(`CBFT_OP_PUSH, 1, 0, 0, 0, 0);
        chk(stack_ptr, 16'hFFFF);
        chk(mem.dmem[0], 16'h00A5);
        run(`CBFT_OP_POP, 6, 0, 0, 0, 0);
        chk(stack_ptr, 16'h0000);
        st(6, 30);
        chk(mem.dmem[30], 16'h00A5);
        $display("t_stack done");
    endtask
    initial begin
        mem.dmem[0] = 8'h00; mem.dmem[1] = 8'h30; mem.dmem[2] = 8'h40; mem.dmem[3] = 8'h12;
        mem.dmem[10] = 8'hA5; mem.dmem[8'h30] = 8'h11; mem.dmem[8'h2F] = 8'h22;
        mem.dmem[8'h46] = 8'h6C; mem.pmem[8'h12] = 8'h5C; mem.pmem[8'h13] = 8'h3D;
        repeat (5) @(posedge clock);
        rstn <= 1;
        t_direct; t_flags; t_tbit; t_ptr; t_ofs; t_prog; t_shift; t_ctrl; t_stack;
        wrap_up;
    end
endmodule // tb_cbft_exec
`default_nettype wire
